// file: rtl/tvfs_pkg.sv
// package of constants for the thermal and drain-source fault supervisor
package tvfs_pkg;
   // register offsets (one register per index)
   localparam logic [3:0] ADDR_THERM_STAT   = 4'h0;
   localparam logic [3:0] ADDR_BRIDGE_SHORT_STATUS_STAT    = 4'h1;
   localparam logic [3:0] ADDR_GLOBAL_STATUS_REG     = 4'h2;
   localparam logic [3:0] ADDR_CTRL         = 4'h3;
   localparam logic [3:0] ADDR_VDS_CFG      = 4'h4;
   localparam logic [3:0] ADDR_CCP_BLK      = 4'h5;
   localparam logic [3:0] ADDR_BRIDGE_CTRL  = 4'h6;
   localparam logic [3:0] ADDR_SW_STAT      = 4'h7;
   // thermal status field positions
   localparam int TS_CAN_LOW   = 0;
   localparam int TS_BLK_OT    = 1;
   localparam int TS_PUMP_OT   = 2;
   localparam int TS_PREWARN   = 3;
   localparam int TS_DEV_OT    = 4;
   localparam int TS_EXT_FLAG  = 5;
   // control field positions
   localparam int CT_PUMP_EN   = 0;
   localparam int CT_EXTEND    = 1;
   localparam int CT_SW_CLRCTL = 2;
   localparam int CT_SW_ALL    = 3;
   localparam int CT_CAN_EN    = 4;
   localparam int CT_SW_ON     = 8;
   localparam int CT_SLEEP_REQ = 12;
   // reset values and overtemperature codes
   localparam logic [2:0] VDS_TH_DEFAULT  = 3'h1;
   localparam logic [1:0] VDS_FLT_DEFAULT = 2'h0;
   localparam logic [1:0] CAN_FAIL_OT     = 2'h1;
   localparam logic [1:0] DEV_STATE_OT    = 2'h1;
   // counts
   localparam logic [4:0] EVENT_LIMIT     = 5'h10;
   localparam int         EXTEND_FACTOR   = 64;
   localparam int         CLK_MHZ         = 250;
   // filter times in ns and cycle counts (filter counts: round down; code_cyc rounds up)
   localparam int FLT0_NS = 500;
   localparam int FLT1_NS = 1000;
   localparam int FLT2_NS = 2000;
   localparam int FLT3_NS = 6000;
   localparam int FLT0_CYC = FLT0_NS * CLK_MHZ / 1000;
   localparam int FLT1_CYC = FLT1_NS * CLK_MHZ / 1000;
   localparam int FLT2_CYC = FLT2_NS * CLK_MHZ / 1000;
   localparam int FLT3_CYC = FLT3_NS * CLK_MHZ / 1000;
   // ccp and blank time: base 587 ns + 266 ns per step
   localparam int TIME_BASE_NS = 587;
   localparam int TIME_STEP_NS = 266;
   // device modes, one-hot
   typedef enum logic [4:0] {
      TVFS_NORMAL  = 5'h01,
      TVFS_FAILSAFE = 5'h02,
      TVFS_COOL    = 5'h04,
      TVFS_RESTART = 5'h08,
      TVFS_SLEEP   = 5'h10
   } tvfs_mode_e;
endpackage : tvfs_pkg

// file: rtl/tvfs_vds_chan.sv
// one half-bridge drain-source monitor with cross-current gap, blank and filter
module tvfs_vds_chan #(
   parameter int CW = 12
) (
   input  wire logic          sys_clk,
   input  wire logic          rstn,
   input  wire logic          clk_en,
   input  wire logic [1:0]    bridge_mode_field,
   input  wire logic          ls_cmp,
   input  wire logic          hs_cmp,
   input  wire logic [CW-1:0] ccp_cyc,
   input  wire logic [CW-1:0] blk_cyc,
   input  wire logic [CW-1:0] flt_cyc,
   input  wire logic          fault_clr,
   output logic               hs_gate,
   output logic               ls_gate,
   output logic               discharge,
   output logic               hs_fault,
   output logic               ls_fault
);
   logic [CW-1:0] ccp_reg;
   logic [CW-1:0] blk_reg;
   logic [CW-1:0] flt_reg;
   logic          latched_reg;
   logic [1:0]    prev_mode_reg;
   // wanted side: 01 = high side on, 10 = low side on
   wire want_hs  = (bridge_mode_field == 2'h1) && !latched_reg;
   wire want_ls  = (bridge_mode_field == 2'h2) && !latched_reg;
   wire mode_chg = (bridge_mode_field != prev_mode_reg) || (latched_reg && ccp_reg == '0);
   wire ccp_busy = (ccp_reg != '0);
   wire blk_busy = (blk_reg != '0);
   wire excess   = (hs_gate && hs_cmp) || (ls_gate && ls_cmp);
   wire trip     = excess && !blk_busy && (flt_reg >= flt_cyc);
   // gates open at once from off; when switching sides the new gate is on in the first cycle, then off for the gap; never both
   assign hs_gate   = want_hs && !ccp_busy; // [R19]
   assign ls_gate   = want_ls && !ccp_busy; // [R19]
   assign discharge = latched_reg && ccp_busy; // [R17]
   // gap, blank and filter counters
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ccp_reg       <= '0;
         blk_reg       <= '0;
         flt_reg       <= '0;
         prev_mode_reg <= 2'h0;
      end else if (clk_en) begin
         prev_mode_reg <= bridge_mode_field;
         if (trip || (bridge_mode_field != prev_mode_reg && prev_mode_reg != 2'h0)) begin
            ccp_reg <= ccp_cyc; // [R19]
         end else if (ccp_busy) begin
            ccp_reg <= ccp_reg - 1'b1;
         end
         if (ccp_reg == 1 || (mode_chg && prev_mode_reg == 2'h0) ||
             (fault_clr && latched_reg)) begin
            blk_reg <= blk_cyc; // [R20]
         end else if (blk_busy) begin
            blk_reg <= blk_reg - 1'b1;
         end
         if (!excess || blk_busy) begin
            flt_reg <= '0; // [R16]
         end else if (flt_reg < flt_cyc) begin
            flt_reg <= flt_reg + 1'b1;
         end
      end
   end
   // fault latch; the bridge stays off until cleared
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         latched_reg <= 1'b0;
         hs_fault    <= 1'b0;
         ls_fault    <= 1'b0;
      end else if (clk_en) begin
         if (trip) begin
            latched_reg <= 1'b1; // [R14] [R15]
            hs_fault    <= hs_fault | (hs_gate && hs_cmp);
            ls_fault    <= ls_fault | (ls_gate && ls_cmp);
         end else if (fault_clr) begin
            latched_reg <= 1'b0; // [R18]
            hs_fault    <= 1'b0;
            ls_fault    <= 1'b0;
         end
      end
   end
   // a latched bridge never drives a gate
   property p_latch_off;
      @(posedge sys_clk) disable iff (!rstn) latched_reg |-> !hs_gate && !ls_gate;
   endproperty
   a_latch_off: assert property (p_latch_off) else $error("gate on while latched"); // [R18]
   property p_no_cross;
      @(posedge sys_clk) disable iff (!rstn) !(hs_gate && ls_gate);
   endproperty
   a_no_cross: assert property (p_no_cross) else $error("both gates on"); // [R19]
   property p_blank_mask;
      @(posedge sys_clk) disable iff (!rstn) clk_en && blk_busy |=> !$rose(latched_reg);
   endproperty
   a_blank_mask: assert property (p_blank_mask) else $error("fault during blank"); // [R20]
endmodule : tvfs_vds_chan

// file: rtl/tvfs_top.sv
// thermal and drain-source fault supervisor top with register port
// Overview of operation
// R1: CAN supply low sets sticky flag
// R2: hot block switches off, shared flag set
// R3: CAN hot: transmitter off, fail field 01
// R4: switches off per config, flags set
// R5: pump hot: flag, enable cleared, discharge (code: gates off, no discharge)
// R6: thermal flags clear only when cool
// R7: prewarning sets sticky flag
// R8: device hot forces fail-safe, cool-down, restart
// R9: device flag clears in normal when cool
// R10: count events; 16 sets extend flag
// R11: extend holds till flag cleared; counter resets
// R12: hot during sleep entry goes fail-safe
// R13: device hot sets global_bit_a bit, state 01
// R14: low-side excess latches bridge off
// R15: high-side excess latches bridge off
// R16: report after blank and filter time
// R17: fault bits plus summary bit set
// R18: bridge off until fault status cleared
// R19: cross-current gap between sides (code: new side on for one cycle before the gap)
// R20: blank time masks detection
// R21: host changes timings only with PWM off
// R22: host changes thresholds only when off
// R23: comparator inputs pass two flops
module tvfs_top #(
   parameter int NB       = 4,
   parameter int NSW      = 4,
   parameter int COOL_CYC = 250000
) (
   input  wire logic             sys_clk,
   input  wire logic             rstn,
   input  wire logic             clk_en,
   input  wire logic [3:0]       addr,
   input  wire logic [15:0]      wdata,
   input  wire logic             wr,
   input  wire logic             rd,
   output logic      [15:0]      rdata,
   input  wire logic             can_low_cmp,
   input  wire logic             can_ot_cmp,
   input  wire logic [NSW-1:0]   sw_ot_cmp,
   input  wire logic             pump_ot_cmp,
   input  wire logic             prewarn_cmp,
   input  wire logic             dev_ot_cmp,
   input  wire logic [NB-1:0]    low_side_monitor_cfg_cmp,
   input  wire logic [NB-1:0]    high_side_monitor_cfg_cmp,
   output logic      [NB*3-1:0]  low_side_vds_threshold,
   output logic      [NB*3-1:0]  high_side_vds_threshold,
   output logic      [NB-1:0]    hs_gate,
   output logic      [NB-1:0]    ls_gate,
   output logic      [NB-1:0]    bridge_discharge,
   output logic                  can_tx_enable,
   output logic      [1:0]       can_fail,
   output logic      [NSW-1:0]   switch_on,
   output logic                  pump_on,
   output logic                  global_bit_a,
   output logic      [1:0]       device_state_field,
   output logic      [4:0]       dev_mode
);
   localparam int CW  = 12;
   localparam int NIN = 5 + NSW + 2 * NB;
   localparam int ECW = $clog2(COOL_CYC * tvfs_pkg::EXTEND_FACTOR + 1);
   // raw comparator bundle and its two-flop synchroniser
   wire  [NIN-1:0] raw = {high_side_monitor_cfg_cmp, low_side_monitor_cfg_cmp, sw_ot_cmp, can_low_cmp, can_ot_cmp,
                          pump_ot_cmp, prewarn_cmp, dev_ot_cmp};
   logic [NIN-1:0] s1_reg;
   logic [NIN-1:0] s2_reg;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         s1_reg <= '0;
         s2_reg <= '0;
      end else if (clk_en) begin
         s1_reg <= raw; // [R23]
         s2_reg <= s1_reg; // [R23]
      end
   end
   wire           dev_ot  = s2_reg[0];
   wire           prewarn = s2_reg[1];
   wire           pump_ot = s2_reg[2];
   wire           can_ot  = s2_reg[3];
   wire           can_low = s2_reg[4];
   wire [NSW-1:0] sw_ot   = s2_reg[5 +: NSW];
   wire [NB-1:0]  ls_cmp  = s2_reg[5+NSW +: NB];
   wire [NB-1:0]  hs_cmp  = s2_reg[5+NSW+NB +: NB];

   // registers
   logic [5:0]       therm_reg;
   logic [NSW-1:0]   swflag_reg;
   logic [15:0]      ctrl_reg;
   logic [15:0]      vds_cfg_reg;
   logic [7:0]       ccp_blk_reg;
   logic [NB*2-1:0]  bmode_reg;
   logic [4:0]       evcnt_reg;
   logic [ECW-1:0]   cool_reg;
   tvfs_pkg::tvfs_mode_e mode_reg;
   logic [NB-1:0]    hsf;
   logic [NB-1:0]    lsf;
   logic [1:0]       flt_sel;

   // converts a 4-bit time code to cycles
   function automatic logic [CW-1:0] code_cyc(input logic [3:0] c);
      int ns;
      ns = tvfs_pkg::TIME_BASE_NS + tvfs_pkg::TIME_STEP_NS * int'(c);
      return CW'((ns * tvfs_pkg::CLK_MHZ + 999) / 1000);
   endfunction : code_cyc

   // register write decode
   wire wr_therm = wr && addr == tvfs_pkg::ADDR_THERM_STAT;
   wire wr_bridge_short_status  = wr && addr == tvfs_pkg::ADDR_BRIDGE_SHORT_STATUS_STAT;
   wire wr_ctrl  = wr && addr == tvfs_pkg::ADDR_CTRL;
   wire wr_vds   = wr && addr == tvfs_pkg::ADDR_VDS_CFG;
   wire wr_ccp   = wr && addr == tvfs_pkg::ADDR_CCP_BLK;
   wire wr_bm    = wr && addr == tvfs_pkg::ADDR_BRIDGE_CTRL;
   wire wr_sw    = wr && addr == tvfs_pkg::ADDR_SW_STAT;
   wire in_norm  = mode_reg == tvfs_pkg::TVFS_NORMAL;
   // clears: write one to clear, only once the condition has gone
   wire [5:0] cond = {1'b0, dev_ot, prewarn, pump_ot, |sw_ot | can_ot | pump_ot, can_low};
   wire [5:0] clr  = wr_therm ? (wdata[5:0] & ~cond &
                     {1'b1, in_norm, 4'hF}) : 6'h0; // [R6] [R9]
   wire dev_clr    = clr[tvfs_pkg::TS_DEV_OT];
   wire ext_off    = wr_ctrl && !wdata[tvfs_pkg::CT_EXTEND] && ctrl_reg[tvfs_pkg::CT_EXTEND];
   wire dev_event  = dev_ot && !therm_reg[tvfs_pkg::TS_DEV_OT] ||
                     dev_ot && (mode_reg == tvfs_pkg::TVFS_NORMAL ||
                                mode_reg == tvfs_pkg::TVFS_SLEEP);
   wire sw_hot     = |(sw_ot & ctrl_reg[tvfs_pkg::CT_SW_ON +: NSW]);
   wire pump_hot   = pump_ot && ctrl_reg[tvfs_pkg::CT_PUMP_EN];
   wire can_hot    = can_ot && ctrl_reg[tvfs_pkg::CT_CAN_EN];
   wire [5:0] set  = {evcnt_reg == tvfs_pkg::EVENT_LIMIT - 1'b1 && dev_event &&
                      ctrl_reg[tvfs_pkg::CT_EXTEND],
                      dev_event, prewarn, pump_hot, sw_hot | can_hot | pump_hot,
                      can_low && ctrl_reg[tvfs_pkg::CT_CAN_EN]};

   // thermal flags: set wins over clear
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         therm_reg <= 6'h0;
      end else if (clk_en) begin
         therm_reg <= (therm_reg & ~clr) | set; // [R1] [R2] [R5] [R6] [R7] [R9] [R10]
      end
   end

   // event counter, cleared with device flag or extend bit
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         evcnt_reg <= 5'h0;
      end else if (clk_en) begin
         if (dev_clr || ext_off) begin
            evcnt_reg <= 5'h0; // [R11]
         end else if (dev_event && mode_reg != tvfs_pkg::TVFS_FAILSAFE &&
                      mode_reg != tvfs_pkg::TVFS_COOL &&
                      evcnt_reg != tvfs_pkg::EVENT_LIMIT) begin
            evcnt_reg <= evcnt_reg + 1'b1; // [R10]
         end
      end
   end

   // control register; hardware clears pump and switch enables on heat
   wire [NSW-1:0] sw_kill = ctrl_reg[tvfs_pkg::CT_SW_ALL] ? {NSW{sw_hot}} :
                            (sw_ot & ctrl_reg[tvfs_pkg::CT_SW_ON +: NSW]);
   wire [NSW-1:0] sw_bits_clr = ctrl_reg[tvfs_pkg::CT_SW_CLRCTL] ? {NSW{1'b0}} : sw_kill;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_reg <= 16'h0000;
      end else if (clk_en) begin
         ctrl_reg <= wr_ctrl ? wdata : ctrl_reg;
         if (pump_hot) begin
            ctrl_reg[tvfs_pkg::CT_PUMP_EN] <= 1'b0; // [R5]
         end
         ctrl_reg[tvfs_pkg::CT_SW_ON +: NSW] <= (wr_ctrl ? wdata[tvfs_pkg::CT_SW_ON +: NSW] :
                                        ctrl_reg[tvfs_pkg::CT_SW_ON +: NSW]) & ~sw_bits_clr; // [R4]
      end
   end

   // per-switch overtemperature flags
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         swflag_reg <= '0;
      end else if (clk_en) begin
         swflag_reg <= (swflag_reg & ~(wr_sw ? wdata[NSW-1:0] & ~sw_ot : '0)) |
                       (sw_ot & ctrl_reg[tvfs_pkg::CT_SW_ON +: NSW]); // [R4] [R6]
      end
   end

   // configuration registers
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         vds_cfg_reg <= {2'h0, tvfs_pkg::VDS_FLT_DEFAULT, 1'b0, tvfs_pkg::VDS_TH_DEFAULT,
                         5'h00, tvfs_pkg::VDS_TH_DEFAULT};
         ccp_blk_reg <= 8'h00;
         bmode_reg   <= '0;
      end else if (clk_en) begin
         if (wr_vds) vds_cfg_reg <= wdata;
         if (wr_ccp) ccp_blk_reg <= wdata[7:0]; // [R21]
         if (wr_bm)  bmode_reg   <= wdata[NB*2-1:0];
      end
   end
   assign flt_sel = vds_cfg_reg[13:12];
   // one threshold code per side shared by all bridges
   assign low_side_vds_threshold  = {NB{vds_cfg_reg[10:8]}}; // [R14] [R22]
   assign high_side_vds_threshold = {NB{vds_cfg_reg[2:0]}}; // [R15]
   wire [CW-1:0] flt_cyc = flt_sel == 2'h0 ? CW'(tvfs_pkg::FLT0_CYC) :
                           flt_sel == 2'h1 ? CW'(tvfs_pkg::FLT1_CYC) :
                           flt_sel == 2'h2 ? CW'(tvfs_pkg::FLT2_CYC) :
                                             CW'(tvfs_pkg::FLT3_CYC); // [R16]

   // device mode machine with cool-down wait
   wire [ECW-1:0] cool_len = therm_reg[tvfs_pkg::TS_EXT_FLAG] ?
                  ECW'(COOL_CYC * tvfs_pkg::EXTEND_FACTOR) : ECW'(COOL_CYC); // [R11]
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         mode_reg <= tvfs_pkg::TVFS_NORMAL;
         cool_reg <= '0;
      end else if (clk_en) begin
         case (mode_reg)
            tvfs_pkg::TVFS_NORMAL: begin
               if (dev_ot) mode_reg <= tvfs_pkg::TVFS_FAILSAFE; // [R8]
               else if (ctrl_reg[tvfs_pkg::CT_SLEEP_REQ]) mode_reg <= tvfs_pkg::TVFS_SLEEP;
            end
            tvfs_pkg::TVFS_SLEEP: begin
               if (dev_ot) mode_reg <= tvfs_pkg::TVFS_FAILSAFE; // [R12]
               else if (!ctrl_reg[tvfs_pkg::CT_SLEEP_REQ]) mode_reg <= tvfs_pkg::TVFS_NORMAL;
            end
            tvfs_pkg::TVFS_FAILSAFE: begin
               if (!dev_ot) begin
                  mode_reg <= tvfs_pkg::TVFS_COOL;
                  cool_reg <= cool_len;
               end
            end
            tvfs_pkg::TVFS_COOL: begin
               if (dev_ot) mode_reg <= tvfs_pkg::TVFS_FAILSAFE;
               else if (cool_reg <= 1) mode_reg <= tvfs_pkg::TVFS_RESTART; // [R8]
               else cool_reg <= cool_reg - 1'b1;
            end
            tvfs_pkg::TVFS_RESTART: mode_reg <= tvfs_pkg::TVFS_NORMAL;
            default: mode_reg <= tvfs_pkg::TVFS_NORMAL;
         endcase
      end
   end
   assign dev_mode = mode_reg;

   // global_bit_a bit and state field
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         global_bit_a       <= 1'b0;
         device_state_field <= 2'h0;
      end else if (clk_en) begin
         if (dev_event) begin
            global_bit_a       <= 1'b1; // [R13]
            device_state_field <= tvfs_pkg::DEV_STATE_OT; // [R13]
         end else if (wr_ctrl && wdata[15]) begin
            global_bit_a       <= 1'b0;
            device_state_field <= 2'h0;
         end
      end
   end

   // block outputs
   assign can_tx_enable = ctrl_reg[tvfs_pkg::CT_CAN_EN] && !can_ot; // [R3]
   assign can_fail      = can_hot ? tvfs_pkg::CAN_FAIL_OT : 2'h0; // [R3]
   assign switch_on     = ctrl_reg[tvfs_pkg::CT_SW_ON +: NSW] & ~sw_kill; // [R4]
   assign pump_on       = ctrl_reg[tvfs_pkg::CT_PUMP_EN] && !pump_ot && in_norm; // [R5]

   // half-bridge channels
   wire           bridge_short_status_clr = wr_bridge_short_status;
   wire [NB-1:0]  any_dis;
   genvar g;
   for (g = 0; g < NB; g++) begin : g_hb
      tvfs_vds_chan #(.CW(CW)) u_chan (
         .sys_clk           (sys_clk),
         .rstn              (rstn),
         .clk_en            (clk_en),
         .bridge_mode_field (pump_on ? bmode_reg[g*2 +: 2] : 2'h0),
         .ls_cmp            (ls_cmp[g]),
         .hs_cmp            (hs_cmp[g]),
         .ccp_cyc           (code_cyc(ccp_blk_reg[3:0])),
         .blk_cyc           (code_cyc(ccp_blk_reg[7:4])),
         .flt_cyc           (flt_cyc),
         .fault_clr         (bridge_short_status_clr), // [R18]
         .hs_gate           (hs_gate[g]),
         .ls_gate           (ls_gate[g]),
         .discharge         (any_dis[g]),
         .hs_fault          (hsf[g]),
         .ls_fault          (lsf[g])
      );
   end
   assign bridge_discharge = any_dis;
   wire bridge_short_status_sum = |{hsf, lsf}; // [R17]

   // read mux, data one cycle after the strobe
   wire [15:0] rd_mux =
      addr == tvfs_pkg::ADDR_THERM_STAT  ? {10'h0, therm_reg} :
      addr == tvfs_pkg::ADDR_BRIDGE_SHORT_STATUS_STAT   ? 16'({hsf, lsf}) :
      addr == tvfs_pkg::ADDR_GLOBAL_STATUS_REG    ? {11'h0, bridge_short_status_sum, global_bit_a, device_state_field,
                                            in_norm} :
      addr == tvfs_pkg::ADDR_CTRL        ? ctrl_reg :
      addr == tvfs_pkg::ADDR_VDS_CFG     ? vds_cfg_reg :
      addr == tvfs_pkg::ADDR_CCP_BLK     ? {8'h0, ccp_blk_reg} :
      addr == tvfs_pkg::ADDR_BRIDGE_CTRL ? 16'(bmode_reg) :
      addr == tvfs_pkg::ADDR_SW_STAT     ? 16'(swflag_reg) : 16'h0000;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) rdata <= 16'h0000;
      else if (clk_en) rdata <= rd ? rd_mux : 16'h0000;
   end

   // leaving fail-safe goes to cool-down, never straight to restart
   property p_cool;
      @(posedge sys_clk) disable iff (!rstn)
         clk_en && mode_reg == tvfs_pkg::TVFS_FAILSAFE && !dev_ot |=>
         mode_reg != tvfs_pkg::TVFS_RESTART;
   endproperty
   a_cool: assert property (p_cool) else $error("restart without cool-down"); // [R8]
   property p_sleep_fs;
      @(posedge sys_clk) disable iff (!rstn)
         clk_en && mode_reg == tvfs_pkg::TVFS_SLEEP && dev_ot |=>
         mode_reg == tvfs_pkg::TVFS_FAILSAFE;
   endproperty
   a_sleep_fs: assert property (p_sleep_fs) else $error("sleep kept on heat"); // [R12]
   property p_fail_bit;
      @(posedge sys_clk) disable iff (!rstn)
         clk_en && dev_event |=> global_bit_a && device_state_field == 2'h1;
   endproperty
   a_fail_bit: assert property (p_fail_bit) else $error("global_bit_a bit not set"); // [R13]
   property p_sticky;
      @(posedge sys_clk) disable iff (!rstn)
         therm_reg[0] && !wr_therm |=> therm_reg[0];
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag self-cleared"); // [R1]
   property p_tx_off;
      @(posedge sys_clk) disable iff (!rstn) can_ot |-> !can_tx_enable;
   endproperty
   a_tx_off: assert property (p_tx_off) else $error("transmitter on while hot"); // [R3]
   property p_pump_off;
      @(posedge sys_clk) disable iff (!rstn) clk_en && pump_hot |=> !ctrl_reg[0];
   endproperty
   a_pump_off: assert property (p_pump_off) else $error("pump enable kept"); // [R5]
   property p_sum;
      @(posedge sys_clk) disable iff (!rstn) (|hsf || |lsf) |-> bridge_short_status_sum;
   endproperty
   a_sum: assert property (p_sum) else $error("summary bit missing"); // [R17]
   property p_cnt_clr;
      @(posedge sys_clk) disable iff (!rstn) clk_en && dev_clr |=> evcnt_reg == 5'h0;
   endproperty
   a_cnt_clr: assert property (p_cnt_clr) else $error("counter not cleared"); // [R11]
endmodule : tvfs_top

// file: dv/tvfs_host.sv
// host model: register writes and reads on the plain port
module tvfs_host (
   input  wire logic        sys_clk,
   output logic      [3:0]  addr,
   output logic      [15:0] wdata,
   output logic             wr,
   output logic             rd,
   input  wire logic [15:0] rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle bus at time zero
   initial begin
      addr  = 4'h0;
      wdata = 16'h0000;
      wr    = 1'b0;
      rd    = 1'b0;
   end
   // one-cycle write; timings and thresholds only while bridges are off
   task automatic reg_wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge sys_clk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= v;
      @(posedge sys_clk);
      wr    <= 1'b0;
      wdata <= ~v; // released data does not keep its value
   endtask : reg_wr
   // one-cycle read; data taken in the cycle after the strobe
   task automatic reg_rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge sys_clk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1;
      v = rdata;
   endtask : reg_rd
endmodule : tvfs_host

// file: dv/test_tvfs_top.sv
// self-checking bench for the fault supervisor
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_errors++; $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
module test_tvfs_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int COOL = 20;
   localparam logic [15:0] MASK [4] = '{16'h0001, 16'h0008, 16'h0006, 16'h0002};
   logic        sys_clk = 1'b0, rstn = 1'b0, wr, rd, dev_ot = 1'b0, can_tx, gfa, pon;
   logic [3:0]  addr, cmp_v = 4'h0, ls_v = 4'h0, hs_v = 4'h0, hsg, lsg, sw_v = 4'h0, swon;
   logic [15:0] wdata, rdata, d;
   logic [11:0] lth, hth;
   logic [1:0]  can_fail, dsf;
   logic [4:0]  mode;
   logic [2:0]  code;
   int          n_errors = 0, check_count = 0, cyc = 0, n, seed = 32'h1164537b;
   tvfs_top #(.COOL_CYC(COOL)) tvfs_top_inst (.sys_clk, .rstn, .clk_en(1'b1), .addr, .wdata,
      .wr, .rd, .rdata, .can_low_cmp(cmp_v[0]), .can_ot_cmp(cmp_v[3]), .sw_ot_cmp(sw_v),
      .pump_ot_cmp(cmp_v[2]), .prewarn_cmp(cmp_v[1]), .dev_ot_cmp(dev_ot), .low_side_monitor_cfg_cmp(ls_v),
      .high_side_monitor_cfg_cmp(hs_v), .low_side_vds_threshold(lth), .high_side_vds_threshold(hth),
      .hs_gate(hsg), .ls_gate(lsg), .bridge_discharge(), .can_tx_enable(can_tx), .can_fail,
      .switch_on(swon), .pump_on(pon), .global_bit_a(gfa), .device_state_field(dsf),
      .dev_mode(mode));
   tvfs_host tvfs_host_inst (.sys_clk, .addr, .wdata, .wr, .rd, .rdata);
   // clock and hang guard
   always #2 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : wrap_up
   task automatic wreg(input logic [3:0] a, input logic [15:0] v);
      tvfs_host_inst.reg_wr(a, v);
   endtask : wreg
   task automatic rreg(input logic [3:0] a);
      tvfs_host_inst.reg_rd(a, d);
   endtask : rreg
   // one device overheat event; returns cycles from cooling to normal
   task automatic dev_event(input logic slp, input logic [15:0] c, output int t);
      wreg(tvfs_pkg::ADDR_CTRL, 16'h8000 | c);
      if (slp) wreg(tvfs_pkg::ADDR_CTRL, 16'h1000 | c);
      repeat (2) @(posedge sys_clk);
      `CHK({gfa, dsf}, 3'b000)
      `CHK(mode, slp ? tvfs_pkg::TVFS_SLEEP : tvfs_pkg::TVFS_NORMAL)
      dev_ot <= 1'b1;
      repeat (4) @(posedge sys_clk);
      `CHK(mode, tvfs_pkg::TVFS_FAILSAFE)
      `CHK({gfa, dsf}, 3'b101)
      dev_ot <= 1'b0;
      t = 0;
      while (mode !== tvfs_pkg::TVFS_NORMAL && t < 3000) begin
         @(posedge sys_clk);
         t++;
      end
      if (slp) wreg(tvfs_pkg::ADDR_CTRL, c);
   endtask : dev_event
   initial begin
      repeat (20) @(posedge sys_clk);
      rstn <= 1'b1;
      rreg(tvfs_pkg::ADDR_THERM_STAT);
      `CHK(d, 16'h0000)
      rreg(4'h9);
      `CHK(d, 16'h0000)
      `CHK({lth, hth}, {8{tvfs_pkg::VDS_TH_DEFAULT}})
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         wreg(tvfs_pkg::ADDR_CTRL, 16'h0011);
         cmp_v[i] <= 1'b1;
         repeat (6) @(posedge sys_clk);
         rreg(tvfs_pkg::ADDR_THERM_STAT);
         `CHK(d, MASK[i])
         if (i == 3) `CHK({can_tx, can_fail}, 3'b001)
         if (i == 2) `CHK(pon, 1'b0)
         wreg(tvfs_pkg::ADDR_THERM_STAT, 16'hFFFF);
         rreg(tvfs_pkg::ADDR_THERM_STAT);
         `CHK(d, MASK[i])
         cmp_v[i] <= 1'b0;
         repeat (6) @(posedge sys_clk);
         if (i == 3) `CHK({can_tx, can_fail}, 3'b100)
         wreg(tvfs_pkg::ADDR_THERM_STAT, 16'hFFFF);
         rreg(tvfs_pkg::ADDR_THERM_STAT);
         `CHK(d, 16'h0000)
      end
      wreg(tvfs_pkg::ADDR_CTRL, 16'h0300);
      sw_v <= 4'h1;
      repeat (6) @(posedge sys_clk);
      `CHK(swon, 4'h2)
      rreg(tvfs_pkg::ADDR_SW_STAT);
      `CHK(d, 16'h0001)
      rreg(tvfs_pkg::ADDR_THERM_STAT);
      `CHK(d, 16'h0002)
      sw_v <= 4'h0;
      repeat (6) @(posedge sys_clk);
      wreg(tvfs_pkg::ADDR_SW_STAT, 16'hFFFF);
      wreg(tvfs_pkg::ADDR_THERM_STAT, 16'hFFFF);
      rreg(tvfs_pkg::ADDR_SW_STAT);
      `CHK(d, 16'h0000)
      $display("test first level done");
      dev_event(1'b0, 16'h0010, n);
      `CHK(n >= COOL && n <= COOL + 8, 1'b1)
      rreg(tvfs_pkg::ADDR_THERM_STAT);
      `CHK(d[4], 1'b1)
      wreg(tvfs_pkg::ADDR_THERM_STAT, 16'hFFFF);
      rreg(tvfs_pkg::ADDR_THERM_STAT);
      `CHK(d, 16'h0000)
      for (int i = 1; i <= 16; i++) begin
         dev_event(1'b0, 16'h0012, n);
         rreg(tvfs_pkg::ADDR_THERM_STAT);
         `CHK(d[5], i == 16)
      end
      dev_event(1'b0, 16'h0012, n);
      `CHK(n >= 64 * COOL && n <= 64 * COOL + 8, 1'b1)
      wreg(tvfs_pkg::ADDR_THERM_STAT, 16'hFFFF);
      dev_event(1'b0, 16'h0012, n);
      `CHK(n >= COOL && n <= COOL + 8, 1'b1)
      dev_event(1'b1, 16'h0012, n);
      `CHK(n >= COOL && n <= COOL + 8, 1'b1)
      $display("test device overheat done");
      repeat (8) begin
         code = 3'($random(seed));
         wreg(tvfs_pkg::ADDR_VDS_CFG, {5'h00, code, 5'h00, ~code});
         repeat (2) @(posedge sys_clk);
         `CHK({lth, hth}, {{4{code}}, {4{~code}}})
      end
      wreg(tvfs_pkg::ADDR_CCP_BLK, 16'h0011);
      wreg(tvfs_pkg::ADDR_VDS_CFG, 16'h0101);
      wreg(tvfs_pkg::ADDR_CTRL, 16'h0001);
      wreg(tvfs_pkg::ADDR_BRIDGE_CTRL, 16'h0001);
      repeat (200) @(posedge sys_clk);
      `CHK(hsg[0] ^ lsg[0], 1'b1)
      ls_v[0] <= 1'b1;
      hs_v[0] <= 1'b1;
      rreg(tvfs_pkg::ADDR_BRIDGE_SHORT_STATUS_STAT);
      `CHK(d, 16'h0000)
      repeat (600) @(posedge sys_clk);
      rreg(tvfs_pkg::ADDR_BRIDGE_SHORT_STATUS_STAT);
      `CHK(d[0] | d[4], 1'b1)
      `CHK({hsg[0], lsg[0]}, 2'b00)
      rreg(tvfs_pkg::ADDR_GLOBAL_STATUS_REG);
      `CHK(d[4], 1'b1)
      ls_v[0] <= 1'b0;
      hs_v[0] <= 1'b0;
      repeat (20) @(posedge sys_clk);
      `CHK({hsg[0], lsg[0]}, 2'b00)
      wreg(tvfs_pkg::ADDR_BRIDGE_SHORT_STATUS_STAT, 16'h0000);
      repeat (400) @(posedge sys_clk);
      `CHK(hsg[0] ^ lsg[0], 1'b1)
      $display("test bridge done");
      wrap_up();
   end
endmodule : test_tvfs_top
